/* File: hw/spf_pkg.sv */
// shared constants, enumerations and carriers for the serial port format and clock block
package spf_pkg;

  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int          CHAR_W       = 16;
  localparam int          CNT_W        = 8;
  localparam int          LANES        = 4;
  localparam int          BUF_DEPTH    = 2;
  localparam logic [3:0]  CLK_DIV_MAX  = 4'h8;
  localparam logic [7:0]  DIV_CNT_RST  = 8'h00;
  localparam logic [7:0]  PH_CNT_RST   = 8'h00;
  localparam logic [4:0]  CHAR_CNT_RST = 5'h00;
  localparam logic [15:0] SHIFT_RST    = 16'h0000;
  localparam logic [4:0]  CHAR_FULL    = 5'h10;
  localparam logic [7:0]  DUR_MIN      = 8'h01;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    LW_SINGLE = 2'h0,
    LW_DUAL   = 2'h1,
    LW_QUAD   = 2'h2
  } spf_lane_e;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_SETUP  = 3'h1,
    ST_ACTIVE = 3'h2,
    ST_INACT  = 3'h3,
    ST_FINISH = 3'h4
  } spf_state_e;

  typedef struct packed {
    logic             en;
    logic             controller;
    logic             three_wire;
    logic             tx_fifo_en;
    logic             rx_fifo_en;
    logic             hd_write;
    logic             clk_pha;
    logic             clk_pol;
    logic [1:0]       lane_width;
    logic [4:0]       char_bits;
    logic [3:0]       clk_div;
    logic [CNT_W-1:0] sck_high_count;
    logic [CNT_W-1:0] sck_low_count;
  } spf_cfg_s;

  typedef struct packed {
    logic [LANES-1:0] o;
    logic [LANES-1:0] oe;
  } spf_lanes_s;

endpackage : spf_pkg

/* File: hw/spf_clkgen.sv */
// power-of-two base tick divider for the serial clock generator
`timescale 1ns/1ps
module spf_clkgen (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       run,
  input  wire logic [3:0] div,
  // base tick
  output logic            tick
);

  // ****************************************
  // divider
  // ****************************************
  logic [7:0] cnt;
  logic [7:0] last;
  logic [3:0] div_eff;

  // values above the legal top are clamped so the counter never wraps early
  always_comb begin
    div_eff = (div > spf_pkg::CLK_DIV_MAX) ? spf_pkg::CLK_DIV_MAX : div;
    last    = 8'((9'h001 << div_eff) - 9'h001);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= spf_pkg::DIV_CNT_RST;
    end else if (!run || cnt == last) begin
      cnt <= spf_pkg::DIV_CNT_RST;
    end else begin
      cnt <= 8'(cnt + 8'h01);
    end
  end

  assign tick = run && (cnt == last);

  a_tick_div_one: assert property (@(posedge clk) disable iff (!rst_n)
    (run && div == 4'h0 && $past(run)) |-> tick)
    else $error("base tick missing with divide by one");
  a_tick_div_two: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && div == 4'h1 && $stable(div)) |=> (!tick || !run) ##1 (tick || !run))
    else $error("base tick period wrong with divide by two");

endmodule : spf_clkgen

/* File: hw/spf_buf2.sv */
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module spf_buf2 (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // fill side
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [spf_pkg::CHAR_W-1:0] in_data,
  // drain side
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [spf_pkg::CHAR_W-1:0]      out_data
);

  logic [spf_pkg::CHAR_W-1:0] mem [spf_pkg::BUF_DEPTH];
  logic                       wr_ptr;
  logic                       rd_ptr;
  logic [1:0]                 count;
  logic                       push;
  logic                       pop;

  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem[0] <= spf_pkg::SHIFT_RST;
      mem[1] <= spf_pkg::SHIFT_RST;
    end else if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) wr_ptr <= ~wr_ptr;
      if (pop)  rd_ptr <= ~rd_ptr;
      count <= 2'(count + {1'b0, push} - {1'b0, pop});
    end
  end

  a_buf_count_track: assert property (@(posedge clk) disable iff (!rst_n)
    (push && !pop && count == 2'h1) |=> (count == 2'h2 && !in_ready))
    else $error("buffer did not report full after second word");

endmodule : spf_buf2

/* File: hw/spf_top.sv */
// serial port lane format, base clock and serial clock engine with phase and polarity
`timescale 1ns/1ps
module spf_top (
  // clock and reset
  input  wire logic                             CLOCK,
  input  wire logic                             RESETN,
  // static configuration
  input  wire spf_pkg::spf_cfg_s                CFG,
  // transmit characters
  input  wire logic                             TX_VALID,
  output logic                                  TX_READY,
  input  wire logic [spf_pkg::CHAR_W-1:0]       TX_DATA,
  // received characters
  output logic                                  RX_VALID,
  input  wire logic                             RX_READY,
  output logic [spf_pkg::CHAR_W-1:0]            RX_DATA,
  // status
  output logic                                  BUSY,
  output logic                                  RX_OVERRUN,
  // serial clock pin
  input  wire logic                             SCK_I,
  output logic                                  SCK_O,
  output logic                                  SCK_OE,
  // select pins
  input  wire logic                             SS0_N_I,
  output logic                                  SS_N_O,
  output logic                                  SS_OE,
  // data lanes
  input  wire logic [spf_pkg::LANES-1:0]        IO_LANE_I,
  output logic [spf_pkg::LANES-1:0]             IO_LANE_O,
  output logic [spf_pkg::LANES-1:0]             IO_LANE_OE
);

  // ****************************************
  // decode helpers
  // ****************************************
  // log2 of the bits moved per serial clock
  function automatic logic [1:0] lane_shift(input logic [1:0] lw);
    case (lw)
      spf_pkg::LW_DUAL: lane_shift = 2'h1;
      spf_pkg::LW_QUAD: lane_shift = 2'h2;
      default:          lane_shift = 2'h0;
    endcase
  endfunction : lane_shift

  // zero duration is stretched to one base period so the clock never stalls
  function automatic logic [7:0] dur_fix(input logic [7:0] d);
    dur_fix = (d == 8'h00) ? spf_pkg::DUR_MIN : d;
  endfunction : dur_fix

  // ****************************************
  // configuration decode
  // ****************************************
  spf_pkg::spf_cfg_s   cfg;
  spf_pkg::spf_state_e state;
  logic [1:0]          sh;
  logic [4:0]          n_cyc;
  logic [5:0]          bits_up;
  logic                ctrl;
  logic                tx_dir;
  logic                rx_take;
  logic [7:0]          act_dur;
  logic [7:0]          inact_dur;

  assign cfg  = CFG;
  assign sh   = lane_shift(cfg.lane_width);
  assign ctrl = cfg.en && cfg.controller;

  always_comb begin
    bits_up = 6'({1'b0, cfg.char_bits} + 6'((6'h01 << sh) - 6'h01));
    n_cyc   = 5'(bits_up >> sh);
  end

  // three-wire direction follows the FIFO enables; wide lanes follow the agreed direction
  always_comb begin
    if (cfg.three_wire && sh == 2'h0) begin
      tx_dir  = cfg.tx_fifo_en && !cfg.rx_fifo_en;
      rx_take = cfg.rx_fifo_en && !cfg.tx_fifo_en;
    end else if (sh != 2'h0) begin
      tx_dir  = cfg.hd_write;
      rx_take = !cfg.hd_write && cfg.rx_fifo_en;
    end else begin
      tx_dir  = 1'b1;
      rx_take = cfg.rx_fifo_en;
    end
  end

  // polarity only swaps which count rules the active phase
  assign act_dur   = dur_fix(cfg.clk_pol ? cfg.sck_low_count : cfg.sck_high_count);
  assign inact_dur = dur_fix(cfg.clk_pol ? cfg.sck_high_count : cfg.sck_low_count);

  // ****************************************
  // base clock
  // ****************************************
  logic base_tick;
  logic gen_run;

  assign gen_run = ctrl && (state != spf_pkg::ST_IDLE);

  spf_clkgen u_clkgen (
    .clk   (CLOCK),
    .rst_n (RESETN),
    .run   (gen_run),
    .div   (cfg.clk_div),
    .tick  (base_tick)
  );

  // ****************************************
  // controller sequencer
  // ****************************************
  logic [7:0] ph_cnt;
  logic [7:0] ph_dur;
  logic       ph_end;
  logic [4:0] clk_cnt;
  logic       last_cyc;
  logic       rx_room;
  logic       c_start;
  logic       c_lead;
  logic       c_trail;
  logic       buf_in_ready;

  assign rx_room  = buf_in_ready || !rx_take;
  assign c_start  = ctrl && (state == spf_pkg::ST_IDLE) && TX_VALID && rx_room;
  assign ph_dur   = (state == spf_pkg::ST_ACTIVE) ? act_dur : inact_dur;
  assign ph_end   = base_tick && ({1'b0, ph_cnt} + 9'h001 >= {1'b0, ph_dur});
  assign last_cyc = (clk_cnt == 5'(n_cyc - 5'h01));
  // select goes low in setup, first clock edge only after a full inactive phase
  assign c_lead   = ph_end && (state == spf_pkg::ST_SETUP || state == spf_pkg::ST_INACT);
  assign c_trail  = ph_end && (state == spf_pkg::ST_ACTIVE);

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      state <= spf_pkg::ST_IDLE;
    end else if (!ctrl) begin
      state <= spf_pkg::ST_IDLE;
    end else begin
      case (state)
        spf_pkg::ST_IDLE:   if (c_start) state <= spf_pkg::ST_SETUP;
        spf_pkg::ST_SETUP:  if (ph_end) state <= spf_pkg::ST_ACTIVE;
        spf_pkg::ST_ACTIVE: if (ph_end) state <= last_cyc ? spf_pkg::ST_FINISH : spf_pkg::ST_INACT;
        spf_pkg::ST_INACT:  if (ph_end) state <= spf_pkg::ST_ACTIVE;
        spf_pkg::ST_FINISH: if (ph_end) state <= spf_pkg::ST_IDLE;
        default:            state <= spf_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      ph_cnt <= spf_pkg::PH_CNT_RST;
    end else if (state == spf_pkg::ST_IDLE || ph_end) begin
      ph_cnt <= spf_pkg::PH_CNT_RST;
    end else if (base_tick) begin
      ph_cnt <= 8'(ph_cnt + 8'h01);
    end
  end

  // ****************************************
  // target edge detection
  // ****************************************
  logic sck_prev;
  logic sel_prev;
  logic t_sel;
  logic t_lead;
  logic t_trail;
  logic t_load;

  // pins are synchronous to CLOCK, so one stored sample is enough for edges
  assign t_sel   = cfg.en && !cfg.controller && !SS0_N_I;
  assign t_lead  = t_sel && (sck_prev == cfg.clk_pol) && (SCK_I != cfg.clk_pol);
  assign t_trail = t_sel && (sck_prev != cfg.clk_pol) && (SCK_I == cfg.clk_pol);

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      sck_prev <= 1'b0;
      sel_prev <= 1'b0;
    end else begin
      sck_prev <= SCK_I;
      sel_prev <= t_sel;
    end
  end

  // ****************************************
  // shared shift engine
  // ****************************************
  logic                       lead;
  logic                       trail;
  logic                       sample_ev;
  logic                       launch_ev;
  logic                       char_done;
  logic                       load;
  logic [spf_pkg::CHAR_W-1:0] tx_shift;
  logic [spf_pkg::CHAR_W-1:0] rx_shift;
  logic [spf_pkg::CHAR_W-1:0] next_rx;
  logic [spf_pkg::CHAR_W-1:0] rx_word;
  logic [spf_pkg::CHAR_W-1:0] load_word;
  logic [3:0]                 lane_in;
  logic [4:0]                 extra;

  assign lead      = ctrl ? c_lead : t_lead;
  assign trail     = ctrl ? c_trail : t_trail;
  // phase picks the sampling edge; polarity never enters here
  assign sample_ev = cfg.clk_pha ? trail : lead;
  assign launch_ev = cfg.clk_pha ? lead : trail;
  assign char_done = trail && last_cyc;
  assign t_load    = cfg.en && !cfg.controller && ((t_sel && !sel_prev) || (char_done && t_sel));
  assign load      = c_start || t_load;
  // target with nothing queued shifts out zeros
  assign load_word = TX_VALID ? TX_DATA : spf_pkg::SHIFT_RST;
  assign TX_READY  = ctrl ? ((state == spf_pkg::ST_IDLE) && rx_room) : t_load;

  always_comb begin
    case (sh)
      2'h1:    lane_in = {2'b00, IO_LANE_I[1:0]};
      2'h2:    lane_in = IO_LANE_I;
      // four-wire controller listens on lane one, everything else on lane zero
      default: lane_in = {3'b000, (ctrl && !cfg.three_wire) ? IO_LANE_I[1] : IO_LANE_I[0]};
    endcase
    case (sh)
      2'h1:    next_rx = {rx_shift[13:0], lane_in[1:0]};
      2'h2:    next_rx = {rx_shift[11:0], lane_in};
      default: next_rx = {rx_shift[14:0], lane_in[0]};
    endcase
    if (!sample_ev) next_rx = rx_shift;
    extra   = 5'((n_cyc << sh) - cfg.char_bits);
    rx_word = (next_rx >> extra) & (16'hffff >> (spf_pkg::CHAR_FULL - cfg.char_bits));
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      tx_shift <= spf_pkg::SHIFT_RST;
    end else if (load) begin
      // characters leave most significant bit first from the top of the register
      tx_shift <= 16'(load_word << (spf_pkg::CHAR_FULL - cfg.char_bits));
    end else if (launch_ev && !(cfg.clk_pha && clk_cnt == spf_pkg::CHAR_CNT_RST)) begin
      tx_shift <= 16'(tx_shift << (5'h01 << sh));
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rx_shift <= spf_pkg::SHIFT_RST;
    end else begin
      rx_shift <= next_rx;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      clk_cnt <= spf_pkg::CHAR_CNT_RST;
    end else if (load || char_done || (!ctrl && !t_sel)) begin
      clk_cnt <= spf_pkg::CHAR_CNT_RST;
    end else if (trail) begin
      clk_cnt <= 5'(clk_cnt + 5'h01);
    end
  end

  // ****************************************
  // receive buffer
  // ****************************************
  logic rx_push;

  assign rx_push = char_done && rx_take;

  spf_buf2 u_rxbuf (
    .clk       (CLOCK),
    .rst_n     (RESETN),
    .in_valid  (rx_push),
    .in_ready  (buf_in_ready),
    .in_data   (rx_word),
    .out_valid (RX_VALID),
    .out_ready (RX_READY),
    .out_data  (RX_DATA)
  );

  // a controller waits for room before starting, so only a target can overrun
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      RX_OVERRUN <= 1'b0;
    end else begin
      RX_OVERRUN <= rx_push && !buf_in_ready;
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  spf_pkg::spf_lanes_s next_lanes;
  logic                act;

  assign act = ctrl ? (state != spf_pkg::ST_IDLE) : t_sel;

  always_comb begin
    next_lanes.o  = {4{tx_shift[15]}};
    next_lanes.oe = 4'h0;
    case (sh)
      2'h1: begin
        next_lanes.o  = {2'b00, tx_shift[15:14]};
        next_lanes.oe = (act && tx_dir) ? 4'h3 : 4'h0;
      end
      2'h2: begin
        next_lanes.o  = tx_shift[15:12];
        next_lanes.oe = (act && tx_dir) ? 4'hf : 4'h0;
      end
      default: begin
        if (cfg.three_wire) begin
          next_lanes.oe = (act && tx_dir) ? 4'h1 : 4'h0;
        end else if (act) begin
          next_lanes.oe = ctrl ? 4'h1 : 4'h2;
        end
      end
    endcase
    if (!cfg.en) next_lanes.oe = 4'h0;
  end

  // all pin outputs register together so clock, select and data keep their spacing
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      SCK_O      <= 1'b0;
      SCK_OE     <= 1'b0;
      SS_N_O     <= 1'b1;
      SS_OE      <= 1'b0;
      IO_LANE_O  <= 4'h0;
      IO_LANE_OE <= 4'h0;
      BUSY       <= 1'b0;
    end else begin
      SCK_O      <= (ctrl && state == spf_pkg::ST_ACTIVE) ? !cfg.clk_pol : cfg.clk_pol;
      SCK_OE     <= ctrl;
      SS_N_O     <= !(ctrl && state != spf_pkg::ST_IDLE);
      SS_OE      <= ctrl;
      IO_LANE_O  <= next_lanes.o;
      IO_LANE_OE <= next_lanes.oe;
      BUSY       <= act;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_disabled_no_drive: assert property (@(posedge CLOCK) disable iff (!RESETN)
    !cfg.en |=> (IO_LANE_OE == 4'h0 && !SCK_OE && !SS_OE))
    else $error("pins driven while port disabled");
  a_three_wire_lane: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (cfg.en && cfg.three_wire && sh == 2'h0) |=> !IO_LANE_OE[1])
    else $error("second lane driven in three-wire format");
  a_three_wire_read: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (cfg.en && cfg.three_wire && sh == 2'h0 && cfg.rx_fifo_en && !cfg.tx_fifo_en) |=> IO_LANE_OE == 4'h0)
    else $error("shared line driven during read");
  a_three_wire_write: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (ctrl && cfg.three_wire && sh == 2'h0 && tx_dir && state == spf_pkg::ST_ACTIVE) |=> IO_LANE_OE == 4'h1)
    else $error("shared line not driven during write");
  a_dual_lanes: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (ctrl && sh == 2'h1 && cfg.hd_write && state == spf_pkg::ST_ACTIVE) |=> IO_LANE_OE == 4'h3)
    else $error("dual write does not drive two lanes");
  a_quad_lanes: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (ctrl && sh == 2'h2 && cfg.hd_write && state == spf_pkg::ST_ACTIVE) |=> IO_LANE_OE == 4'hf)
    else $error("quad write does not drive four lanes");
  a_target_ignores: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (cfg.en && !cfg.controller && SS0_N_I) |-> (!t_lead && !t_trail && !t_load) ##1 IO_LANE_OE == 4'h0)
    else $error("deselected target reacted to the link");
  a_select_first: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (ctrl && SCK_O != cfg.clk_pol && $stable(cfg.clk_pol)) |-> !SS_N_O)
    else $error("serial clock left idle level without select");
  a_idle_level: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (ctrl && state == spf_pkg::ST_IDLE) [*2] |-> SCK_O == cfg.clk_pol)
    else $error("serial clock not at idle level between transfers");
  a_phase_edges: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (ctrl && c_lead && !cfg.clk_pha) |-> (sample_ev && !launch_ev))
    else $error("phase zero does not sample on the first edge");

endmodule : spf_top

/* File: tb/spf_tgt_model.sv */
// behavioural single-lane target facing the block in controller mode
`timescale 1ns/1ps
module spf_tgt_model (
  // serial pins
  input  wire logic        sck,
  input  wire logic        ss_n,
  input  wire logic        mosi,
  output logic             miso,
  // setup
  input  wire logic        pha,
  input  wire logic [4:0]  bits,
  input  wire logic [15:0] word,
  // captured character
  output logic [15:0]      got
);
  logic [15:0] sr = 16'h0000;
  logic        lastb = 1'b0;
  int          e = 0;
  // a released line shows the inverse of its last bit, never a stale copy
  assign miso = ss_n ? ~lastb : sr[bits-1];
  always @(negedge ss_n) begin
    sr = word;
    got = 16'h0000;
    e = 0;
  end
  always @(posedge ss_n) lastb = sr[bits-1];
  always @(sck) if (!ss_n) begin
    e++;
    if (e[0] != pha) got = {got[14:0], mosi};
    else if (e > 1) sr = sr << 1;
  end
endmodule : spf_tgt_model

/* File: tb/tb_spf_top.sv */
// self-checking bench for the serial format and clock block
`timescale 1ns/1ps
module tb_spf_top;
  // ****
  // signals
  // ****
  logic CLOCK = 1'b0, RESETN = 1'b0, TX_VALID = 1'b0, RX_READY = 1'b1, SCK_I = 1'b0, SS0_N_I = 1'b1;
  logic TX_READY, RX_VALID, BUSY, RX_OVERRUN, SCK_O, SCK_OE, SS_N_O, SS_OE, miso, prev;
  logic [15:0] TX_DATA = 16'h0000, RX_DATA, got, tgt_word = 16'h0000;
  logic [3:0]  IO_LANE_I, IO_LANE_O, IO_LANE_OE, oe_seen;
  logic [31:0] rnd = 32'ha996e949;
  spf_pkg::spf_cfg_s cfg = '0, c;
  logic [15:0] exp_q[$];
  int fail_count = 0, tests_run = 0, cyc = 0, run = 0, hi_run = 0, lo_run = 0, edges = 0;

  always #2 CLOCK = ~CLOCK;
  // undriven lanes carry the inverse of the block's own output, except the model's miso lane (lane one in four-wire, lane zero in three-wire)
  assign IO_LANE_I = (IO_LANE_OE & IO_LANE_O) | (~IO_LANE_OE & {~IO_LANE_O[3:2],
                     cfg.three_wire ? ~IO_LANE_O[1] : miso, cfg.three_wire ? miso : ~IO_LANE_O[0]});

  spf_top DUT (.CLOCK(CLOCK), .RESETN(RESETN), .CFG(cfg), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
    .TX_DATA(TX_DATA), .RX_VALID(RX_VALID), .RX_READY(RX_READY), .RX_DATA(RX_DATA), .BUSY(BUSY),
    .RX_OVERRUN(RX_OVERRUN), .SCK_I(SCK_I), .SCK_O(SCK_O), .SCK_OE(SCK_OE), .SS0_N_I(SS0_N_I),
    .SS_N_O(SS_N_O), .SS_OE(SS_OE), .IO_LANE_I(IO_LANE_I), .IO_LANE_O(IO_LANE_O), .IO_LANE_OE(IO_LANE_OE));
  spf_tgt_model u_tgt (.sck(SCK_O), .ss_n(SS_N_O), .mosi(IO_LANE_I[0]), .miso(miso), .pha(cfg.clk_pha),
    .bits(cfg.char_bits), .word(tgt_word), .got(got));

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [15:0] mask();
    return 16'((17'h00001 << cfg.char_bits) - 17'h00001);
  endfunction : mask
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  // phase lengths, lane drive, received words and the hang limit
  always @(posedge CLOCK) begin
    cyc++;
    prev <= SCK_O;
    run <= (SCK_O == prev) ? run + 1 : 1;
    if (SCK_O != prev && prev) hi_run <= run;
    if (SCK_O != prev && !prev) lo_run <= run;
    if (!SS_N_O) begin
      oe_seen <= oe_seen | IO_LANE_OE;
      if (SCK_O != prev) edges <= edges + 1;
    end else if (TX_VALID) begin
      oe_seen <= 4'h0;
      edges <= 0;
    end
    if (RX_VALID === 1'b1 && RX_READY) begin
      if (exp_q.size() == 0) chk("rx_extra", 16'h0001, 16'h0000);
      else chk("rx_data", RX_DATA, exp_q.pop_front());
    end
    if (cyc > 30000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic setcfg(spf_pkg::spf_cfg_s n);
    cfg.en = 1'b0;
    repeat (2) @(posedge CLOCK);
    n.en = 1'b0;
    #1 cfg = n;
    @(posedge CLOCK);
    #1 cfg.en = 1'b1;
    repeat (3) @(posedge CLOCK);
    #1;
  endtask : setcfg
  task automatic xfer(logic push);
    logic r;
    rnd = lfsr(rnd);
    TX_DATA = rnd[15:0] & mask();
    tgt_word = rnd[31:16];
    if (push) exp_q.push_back(tgt_word & mask());
    TX_VALID = 1'b1;
    do begin
      @(negedge CLOCK) r = TX_READY;
      @(posedge CLOCK);
    end while (r !== 1'b1);
    #1 TX_VALID = 1'b0;
    wait (BUSY === 1'b1);
    wait (BUSY === 1'b0);
    repeat (3) @(posedge CLOCK);
    #1;
  endtask : xfer

  initial begin
    repeat (10) @(posedge CLOCK);
    #1 RESETN = 1'b1;
    repeat (2) @(posedge CLOCK);
    #1 chk("oe_off", 16'({SCK_OE, SS_OE, IO_LANE_OE}), 16'h0000);
    for (int m = 0; m < 4; m++) begin
      c = '0;
      c.controller = 1'b1;
      c.tx_fifo_en = 1'b1;
      c.rx_fifo_en = 1'b1;
      c.clk_pha = m[1];
      c.clk_pol = m[0];
      c.char_bits = 5'(5 + 3 * m);
      c.clk_div = 4'(m);
      c.sck_high_count = 8'(m + 1);
      c.sck_low_count = 8'h02;
      setcfg(c);
      chk("sck_idle", 16'(SCK_O), 16'(m[0]));
      chk("sck_oe", 16'(SCK_OE), 16'h0001);
      xfer(1'b1);
      chk("tgt_rx", got, TX_DATA);
      chk("sck_high", 16'(hi_run), 16'((m + 1) << m));
      chk("sck_low", 16'(lo_run), 16'(2 << m));
      chk("sck_rest", 16'(SCK_O), 16'(m[0]));
      chk("sck_edges", 16'(edges), 16'(2 * (5 + 3 * m)));
    end
    c.clk_pha = 1'b0;
    c.clk_pol = 1'b0;
    c.char_bits = 5'h08;
    c.three_wire = 1'b1;
    c.tx_fifo_en = 1'b0;
    setcfg(c);
    xfer(1'b1);
    chk("oe_read", 16'(oe_seen), 16'h0000);
    c.rx_fifo_en = 1'b0;
    c.tx_fifo_en = 1'b1;
    setcfg(c);
    xfer(1'b0);
    chk("oe_write", 16'(oe_seen), 16'h0001);
    chk("tgt_rx3", got, TX_DATA);
    c.three_wire = 1'b0;
    c.rx_fifo_en = 1'b1;
    setcfg(c);
    RX_READY = 1'b0;
    xfer(1'b1);
    xfer(1'b1);
    chk("rx_full_stall", 16'(TX_READY), 16'h0000);
    RX_READY = 1'b1;
    xfer(1'b1);
    c.rx_fifo_en = 1'b0;
    c.hd_write = 1'b1;
    for (int w = 1; w < 3; w++) begin
      c.lane_width = 2'(w);
      setcfg(c);
      xfer(1'b0);
      chk("oe_wide", 16'(oe_seen), (w == 1) ? 16'h0003 : 16'h000f);
      chk("sck_wide", 16'(edges), (w == 1) ? 16'h0008 : 16'h0004);
    end
    c.lane_width = 2'h0;
    c.hd_write = 1'b0;
    c.rx_fifo_en = 1'b1;
    c.controller = 1'b0;
    setcfg(c);
    // idle target shifts zeros, so its own lane zero reads back as ones
    exp_q.push_back(mask());
    SS0_N_I = 1'b0;
    repeat (16) #8 SCK_I = ~SCK_I;
    chk("tgt_sel", 16'({BUSY, IO_LANE_OE}), 16'h0012);
    #8 SS0_N_I = 1'b1;
    repeat (6) #8 SCK_I = ~SCK_I;
    chk("tgt_ignore", 16'({BUSY, RX_VALID, RX_OVERRUN, IO_LANE_OE}), 16'h0000);
    chk("rx_left", 16'(exp_q.size()), 16'h0000);
    finish_test();
  end
endmodule : tb_spf_top
